// ==== logic/gx_dev.sv ====
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "gx_map.svh"
// Expander end: register file, pins, edge interrupts, lookup tables
module gx_dev
	import gx_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `GX_DEV_ADDR
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Link
	gx_link_if.dev           lnk,
	// Pins
	input  wire logic [15:0] i_pin,
	output logic      [15:0] o_pin,
	output logic      [15:0] o_pin_oe_n,
	output logic      [15:0] o_pullup,
	output logic             o_boost
);
	gx_dev_s     r;
	gx_dev_s     n;
	logic [15:0] clr;
	logic [15:0] rise;
	logic [15:0] fall;
	logic [15:0] ev;
	logic [7:0]  rdat;
	logic        scl_r;
	logic        scl_f;
	logic        start;
	logic        stop;

	// Link edges from the second synchroniser stage onward
	assign scl_r = r.scl_s[1] & ~r.scl_s[2];
	assign scl_f = ~r.scl_s[1] & r.scl_s[2];
	assign start = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
	assign stop  = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];

	// Pin edges and per-pin sense selection (01 rise, 10 fall, 11 both)
	assign rise = r.pin_s2 & ~r.pin_prev;
	assign fall = ~r.pin_s2 & r.pin_prev;
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			ev[i] = (r.sense[2*i] & rise[i]) | (r.sense[2*i+1] & fall[i]);  // [R10]
		end
	end

	// Read mux; the data register returns live pin levels
	always_comb begin
		case (r.ra)
			`GX_DIR_B:  rdat = r.dir[15:8];
			`GX_DIR_A:  rdat = r.dir[7:0];
			`GX_PUP_B:  rdat = r.pup[15:8];
			`GX_PUP_A:  rdat = r.pup[7:0];
			`GX_DATA_B: rdat = r.pin_s2[15:8];  // [R11]
			`GX_DATA_A: rdat = r.pin_s2[7:0];
			`GX_MASK_B: rdat = r.mask[15:8];
			`GX_MASK_A: rdat = r.mask[7:0];
			`GX_SNSH_B: rdat = r.sense[31:24];
			`GX_SNSL_B: rdat = r.sense[23:16];
			`GX_SNSH_A: rdat = r.sense[15:8];
			`GX_SNSL_A: rdat = r.sense[7:0];
			`GX_PEND_B: rdat = r.pend[15:8];  // [R11]
			`GX_PEND_A: rdat = r.pend[7:0];
			`GX_MODE:   rdat = r.mode;
			`GX_LUT_U:  rdat = r.lut_u;
			`GX_LUT_L:  rdat = r.lut_l;
			`GX_ADV:    rdat = r.adv;
			default:    rdat = 8'h00;
		endcase
	end

	// Next state
	always_comb begin
		n   = r;
		clr = 16'h0000;
		// Synchronisers: stage 0 feeds only stage 1
		n.scl_s  = {r.scl_s[1:0], lnk.scl};
		n.sda_s  = {r.sda_s[1:0], lnk.sda};
		n.pin_s1 = i_pin;
		n.pin_s2 = r.pin_s1;
		n.pin_prev = r.pin_s2;
		// Link slave
		if (start) begin
			n.st       = DS_RX;
			n.idx      = 2'h0;
			n.nbit     = 4'h0;
			n.sda_oe_n = 1'b1;
		end else if (stop) begin
			n.st       = DS_IDLE;
			n.sda_oe_n = 1'b1;
		end else begin
			case (r.st)
				DS_RX: begin
					if (scl_r && r.nbit < 4'h8) begin
						n.sh   = {r.sh[6:0], r.sda_s[1]};
						n.nbit = r.nbit + 4'h1;
					end else if (scl_f && r.nbit == 4'h8) begin
						n.st       = DS_ACK;
						n.sda_oe_n = 1'b0;
						case (r.idx)
							2'h0: begin
								n.rw = r.sh[0];
								if (r.sh[7:1] != DEV_ADDR) begin
									n.st       = DS_WAIT;
									n.sda_oe_n = 1'b1;
								end
							end
							2'h1: n.ra = r.sh;
							default: begin
								// Register write
								case (r.ra)
									`GX_DIR_B:  n.dir[15:8] = r.sh;  // [R9]
									`GX_DIR_A:  n.dir[7:0] = r.sh;
									`GX_PUP_B:  n.pup[15:8] = r.sh;  // [R9]
									`GX_PUP_A:  n.pup[7:0] = r.sh;
									`GX_DATA_B: n.dout[15:8] = r.sh;
									`GX_DATA_A: n.dout[7:0] = r.sh;
									`GX_MASK_B: n.mask[15:8] = r.sh;  // [R10]
									`GX_MASK_A: n.mask[7:0] = r.sh;
									`GX_SNSH_B: n.sense[31:24] = r.sh;
									`GX_SNSL_B: n.sense[23:16] = r.sh;
									`GX_SNSH_A: n.sense[15:8] = r.sh;
									`GX_SNSL_A: n.sense[7:0] = r.sh;
									`GX_PEND_B: clr[15:8] = r.sh;  // [R12]
									`GX_PEND_A: clr[7:0] = r.sh;  // [R12]
									`GX_MODE:   n.mode = r.sh;
									`GX_LUT_U:  n.lut_u = r.sh;
									`GX_LUT_L:  n.lut_l = r.sh;
									`GX_ADV:    n.adv = r.sh & `GX_ADV_WMASK;  // [R7] [R8]
									default:    ;
								endcase
							end
						endcase
					end
				end
				DS_ACK: begin
					if (scl_f) begin
						n.sda_oe_n = 1'b1;
						n.nbit     = 4'h0;
						n.st       = DS_RX;
						n.idx      = r.idx + 2'h1;
						if (r.idx == 2'h2) begin
							n.st = DS_WAIT;
						end else if (r.idx == 2'h1 && r.rw) begin
							// Start of read data byte
							n.st       = DS_TX;
							n.sh       = rdat;
							n.sda_oe_n = rdat[7];
							n.nbit     = 4'h1;
							if ((r.ra == `GX_DATA_B || r.ra == `GX_DATA_A)
								&& r.adv[`GX_ADV_AUTOCLR]) begin
								clr = 16'hffff;  // [R5]
							end
						end
					end
				end
				DS_TX: begin
					if (scl_f) begin
						if (r.nbit == 4'h8) begin
							n.sda_oe_n = 1'b1;
							n.st       = DS_WAIT;
						end else begin
							n.sh       = {r.sh[6:0], 1'b0};
							n.sda_oe_n = r.sh[6];
							n.nbit     = r.nbit + 4'h1;
						end
					end
				end
				default: ;
			endcase
		end
		// Pending flags: a new event beats a clear in the same cycle
		n.pend     = (r.pend & ~clr) | (ev & ~r.mask);  // [R6] [R12]
		n.irq_oe_n = ~|n.pend;
		// Pin drive with table overrides in 3-to-2 mode
		n.pin_o = r.dout;
		if (r.mode[3:2] == `GX_MODE_3TO2) begin
			n.pin_o[12] = r.lut_u[r.pin_s2[10:8]];  // [R1] [R3] [R13]
		end
		if (r.mode[1:0] == `GX_MODE_3TO2) begin
			n.pin_o[4] = r.lut_l[r.pin_s2[2:0]];  // [R2] [R4] [R13]
		end
	end

	// State register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r          <= '0;
			r.dir      <= `GX_DIR_RST;
			r.mask     <= `GX_MASK_RST;
			r.adv      <= `GX_ADV_RST;
			r.sda_oe_n <= 1'b1;
			r.irq_oe_n <= 1'b1;
			r.scl_s    <= 3'h7;
			r.sda_s    <= 3'h7;
		end else begin
			r <= n;
		end
	end

	// Outputs
	assign o_pin          = r.pin_o;
	assign o_pin_oe_n     = r.dir;  // [R9]
	assign o_pullup       = r.pup;
	assign o_boost        = r.adv[`GX_ADV_BOOST];  // [R7]
	assign lnk.d_sda_o    = 1'b0;
	assign lnk.d_sda_oe_n = r.sda_oe_n;
	assign lnk.irq_o      = 1'b0;
	assign lnk.irq_oe_n   = r.irq_oe_n;
endmodule

// ==== logic/gx_host.sv ====
`timescale 1ns/1ps
`include "gx_map.svh"
// Controller end: Wishbone registers drive link transfers
module gx_host
	import gx_pkg::*;
#(
	parameter logic [7:0] QTR_CYC = 8'(`GX_QTR_CYC)
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// Interrupt
	output logic             o_int,
	// Link
	gx_link_if.host          lnk
);
	gx_host_s   r;
	gx_host_s   n;
	logic       req;
	logic       wr;
	logic       tick;
	logic       rdbyte;
	logic [2:0] ev;
	logic [2:0] iclr;

	assign req    = i_wb_cyc & i_wb_stb & ~r.wb_ack;
	// Writes land on the edge at which the master samples ack high
	assign wr     = i_wb_cyc & i_wb_stb & r.wb_ack & i_wb_we & i_wb_sel[0];
	assign tick   = (r.st != HS_IDLE) && (r.qcnt == QTR_CYC - 8'h1);
	assign rdbyte = r.rw && r.byte_i == 2'h2;

	always_comb begin
		n        = r;
		ev       = 3'h0;
		iclr     = 3'h0;
		n.sda_s  = {r.sda_s[0], lnk.sda};
		n.irq_s  = {r.irq_s[1:0], lnk.irq_n};
		n.wb_ack = req;
		// Register access over Wishbone
		case (i_wb_adr)
			`GX_H_CTRL:   n.wb_dat = {9'h0, r.dadr, r.ra, 6'h0, r.rw, r.busy};
			`GX_H_WDATA:  n.wb_dat = {24'h0, r.wd};
			`GX_H_RDATA:  n.wb_dat = {24'h0, r.rx};
			`GX_H_STATUS: n.wb_dat = {29'h0, ~r.irq_s[1], r.nack, r.busy};
			`GX_H_ISTAT:  n.wb_dat = {29'h0, r.istat};
			`GX_H_IMASK:  n.wb_dat = {29'h0, r.imask};
			default:      n.wb_dat = 32'h0;
		endcase
		if (wr) begin
			case (i_wb_adr)
				`GX_H_CTRL: begin
					if (!r.busy && i_wb_dat[0]) begin
						n.rw       = i_wb_dat[1];
						n.ra       = i_wb_dat[15:8];
						n.dadr     = i_wb_dat[22:16];
						n.busy     = 1'b1;
						n.nack     = 1'b0;
						n.st       = HS_START;
						n.q        = 2'h0;
						n.qcnt     = 8'h0;
						n.sda_oe_n = 1'b0;
					end
				end
				`GX_H_WDATA: n.wd = i_wb_dat[7:0];
				`GX_H_ISTAT: iclr = i_wb_dat[2:0];
				`GX_H_IMASK: n.imask = i_wb_dat[2:0];
				default:     ;
			endcase
		end
		// Quarter-period timebase
		if (r.st != HS_IDLE) begin
			n.qcnt = tick ? 8'h0 : r.qcnt + 8'h1;
		end
		if (tick) begin
			n.q = r.q + 2'h1;
			case (r.st)
				HS_START: begin
					if (r.q == 2'h0) begin
						n.scl = 1'b0;
					end else if (r.q == 2'h3) begin
						n.st       = HS_BIT;
						n.bit_i    = 4'h0;
						n.byte_i   = 2'h0;
						n.tx       = {r.dadr, r.rw};
						n.sda_oe_n = r.dadr[6];
					end
				end
				HS_BIT: begin
					if (r.q == 2'h0) begin
						n.scl = 1'b1;
					end else if (r.q == 2'h2) begin
						n.scl = 1'b0;
						if (r.bit_i < 4'h8 && rdbyte) begin
							n.rx = {r.rx[6:0], r.sda_s[1]};
						end else if (r.bit_i == 4'h8 && !rdbyte && r.sda_s[1]) begin
							n.nack = 1'b1;
							ev[`GX_EV_NACK] = 1'b1;
						end
					end else if (r.q == 2'h3) begin
						if (r.bit_i == 4'h8) begin
							if (r.nack || r.byte_i == 2'h2) begin
								n.st       = HS_STOP;
								n.sda_oe_n = 1'b0;
							end else begin
								n.byte_i   = r.byte_i + 2'h1;
								n.bit_i    = 4'h0;
								n.tx       = (r.byte_i == 2'h0) ? r.ra : r.wd;
								n.sda_oe_n = (r.byte_i == 2'h1 && r.rw) | n.tx[7];
							end
						end else begin
							n.bit_i    = r.bit_i + 4'h1;
							n.tx       = {r.tx[6:0], 1'b0};
							n.sda_oe_n = (r.bit_i == 4'h7) | rdbyte | r.tx[6];
						end
					end
				end
				HS_STOP: begin
					if (r.q == 2'h0) begin
						n.scl = 1'b1;
					end else if (r.q == 2'h1) begin
						n.sda_oe_n = 1'b1;
					end else if (r.q == 2'h3) begin
						n.st = HS_IDLE;
						n.busy = 1'b0;
						ev[`GX_EV_DONE] = 1'b1;
					end
				end
				default: ;
			endcase
		end
		// Falling interrupt line from the expander
		ev[`GX_EV_IRQ] = r.irq_s[2] & ~r.irq_s[1];  // [R11]
		// Sticky status: an event beats a clear
		n.istat = (r.istat & ~iclr) | ev;
		n.int_o = |(n.istat & r.imask);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r          <= '0;
			r.scl      <= 1'b1;
			r.sda_oe_n <= 1'b1;
			r.sda_s    <= 2'h3;
			r.irq_s    <= 3'h7;
		end else begin
			r <= n;
		end
	end

	assign o_wb_dat       = r.wb_dat;
	assign o_wb_ack       = r.wb_ack;
	assign o_int          = r.int_o;
	assign lnk.scl        = r.scl;
	assign lnk.h_sda_o    = 1'b0;
	assign lnk.h_sda_oe_n = r.sda_oe_n;
endmodule

// ==== logic/gx_link_if.sv ====
`timescale 1ns/1ps
// Two-wire link: host-made clock, open-drain data and interrupt
interface gx_link_if;
	logic scl;
	logic h_sda_o;
	logic h_sda_oe_n;
	logic d_sda_o;
	logic d_sda_oe_n;
	logic irq_o;
	logic irq_oe_n;
	logic sda;
	logic irq_n;

	// Wired-and with pull-up
	assign sda   = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
	assign irq_n = irq_oe_n | irq_o;

	modport host (output scl, output h_sda_o, output h_sda_oe_n, input sda, input irq_n);
	modport dev  (input scl, input sda, output d_sda_o, output d_sda_oe_n, output irq_o, output irq_oe_n);
endinterface

// ==== logic/gx_map.svh ====
`ifndef GX_MAP_SVH
`define GX_MAP_SVH
// Summary of operation
// R1 - Upper 3-to-2 mode: pin 12 from table
// R2 - Lower 3-to-2 mode: pin 4 from table
// R3 - Upper second table unused outside 3-to-2
// R4 - Lower second table unused outside 3-to-2
// R5 - Autoclear on: data read clears pending
// R6 - Autoclear off: flags stay until cleared
// R7 - Advanced bit 1 holds boost enable
// R8 - Host writes zero to reserved bits
// R9 - All-ones direction/pull-up: inputs, pull-ups
// R10 - Zero mask unmasks; 0xaa senses falling
// R11 - Host reads data/source after interrupt
// R12 - Writing ones clears matching pending flags
// R13 - Tables follow present select pin levels

// Device register offsets
`define GX_DIR_B      8'h00
`define GX_DIR_A      8'h01
`define GX_PUP_B      8'h02
`define GX_PUP_A      8'h03
`define GX_DATA_B     8'h04
`define GX_DATA_A     8'h05
`define GX_MASK_B     8'h06
`define GX_MASK_A     8'h07
`define GX_SNSH_B     8'h08
`define GX_SNSL_B     8'h09
`define GX_SNSH_A     8'h0a
`define GX_SNSL_A     8'h0b
`define GX_PEND_B     8'h0c
`define GX_PEND_A     8'h0d
`define GX_MODE       8'h0e
`define GX_LUT_U      8'h2a
`define GX_LUT_L      8'h2b
`define GX_ADV        8'had
// Device reset values and fields
`define GX_DIR_RST    16'hffff
`define GX_MASK_RST   16'hffff
`define GX_ADV_RST    8'h00
`define GX_ADV_WMASK  8'h06
`define GX_ADV_AUTOCLR 2
`define GX_ADV_BOOST  1
`define GX_MODE_3TO2  2'h2
`define GX_DEV_ADDR   7'h20
// Controller register offsets and fields
`define GX_H_CTRL     8'h00
`define GX_H_WDATA    8'h04
`define GX_H_RDATA    8'h08
`define GX_H_STATUS   8'h0c
`define GX_H_ISTAT    8'h10
`define GX_H_IMASK    8'h14
`define GX_EV_DONE    0
`define GX_EV_NACK    1
`define GX_EV_IRQ     2
// Link timing: a quarter of the serial clock period
`define GX_CLK_NS     50
`define GX_QTR_NS     250
`define GX_QTR_CYC    ((`GX_QTR_NS + `GX_CLK_NS - 1) / `GX_CLK_NS)
`endif

// ==== logic/gx_pkg.sv ====
package gx_pkg;
	typedef enum logic [2:0] {
		DS_IDLE = 3'b000,
		DS_RX   = 3'b001,
		DS_ACK  = 3'b010,
		DS_TX   = 3'b011,
		DS_WAIT = 3'b100
	} gx_dev_st_e;

	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_START = 2'b01,
		HS_BIT   = 2'b10,
		HS_STOP  = 2'b11
	} gx_host_st_e;

	typedef struct packed {
		gx_dev_st_e  st;
		logic [3:0]  nbit;
		logic [1:0]  idx;
		logic        rw;
		logic [7:0]  sh;
		logic [7:0]  ra;
		logic        sda_oe_n;
		logic [2:0]  scl_s;
		logic [2:0]  sda_s;
		logic [15:0] pin_s1;
		logic [15:0] pin_s2;
		logic [15:0] pin_prev;
		logic [15:0] dir;
		logic [15:0] dout;
		logic [15:0] pup;
		logic [15:0] mask;
		logic [15:0] pend;
		logic [31:0] sense;
		logic [7:0]  lut_u;
		logic [7:0]  lut_l;
		logic [7:0]  mode;
		logic [7:0]  adv;
		logic [15:0] pin_o;
		logic        irq_oe_n;
	} gx_dev_s;

	typedef struct packed {
		gx_host_st_e st;
		logic [1:0]  q;
		logic [7:0]  qcnt;
		logic [3:0]  bit_i;
		logic [1:0]  byte_i;
		logic [7:0]  tx;
		logic [7:0]  rx;
		logic [6:0]  dadr;
		logic        rw;
		logic [7:0]  ra;
		logic [7:0]  wd;
		logic        busy;
		logic        nack;
		logic        scl;
		logic        sda_oe_n;
		logic [1:0]  sda_s;
		logic [2:0]  irq_s;
		logic [2:0]  istat;
		logic [2:0]  imask;
		logic        wb_ack;
		logic [31:0] wb_dat;
		logic        int_o;
	} gx_host_s;
endpackage

// ==== tb/gx_monitor.sv ====
`timescale 1ns/1ps
// Watches the link and the expander pins
module gx_monitor (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst,
	// Link
	input wire logic        scl,
	input wire logic        sda,
	input wire logic        h_sda_oe_n,
	input wire logic        d_sda_oe_n,
	input wire logic        irq_oe_n,
	// Pins
	input wire logic [15:0] i_pin,
	input wire logic [15:0] o_pin,
	input wire logic        o_boost
);
	logic       scl_q;
	logic       sda_q;
	logic       in_frame;
	logic [5:0] rises;
	logic [3:0] idle_cnt;
	logic       stop_w;

	// Stop seen on the wire
	assign stop_w = scl & scl_q & ~sda_q & sda;

	// Frame tracking: clock pulses per frame, idle time after it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			in_frame <= 1'b0;
			rises <= 6'h00;
			idle_cnt <= 4'h0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl && scl_q && sda_q && !sda) begin
				in_frame <= 1'b1;
				rises <= 6'h00;
			end else if (stop_w) begin
				in_frame <= 1'b0;
			end else if (in_frame && scl && !scl_q) begin
				rises <= rises + 6'h01;
			end
			idle_cnt <= in_frame ? 4'h0 : (idle_cnt == 4'hf ? idle_cnt : idle_cnt + 4'h1);
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_dev_sda_low: assert property ($changed(d_sda_oe_n) |-> !scl)
		else $error("expander moved data with clock high");
	a_host_frames_only: assert property (scl && $past(scl) && $changed(sda) |-> $changed(h_sda_oe_n))
		else $error("start or stop not made by controller");
	a_scl_high_len: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high too short");
	a_scl_low_len: assert property ($fell(scl) |-> !scl [*4])
		else $error("clock low too short");
	a_frame_pulse_count: assert property (stop_w && in_frame |-> rises == 6'h1c || rises == 6'h0a)
		else $error("wrong clock pulse count in frame");
	a_boost_idle_stable: assert property (idle_cnt >= 4'h2 |-> $stable(o_boost))
		else $error("boost moved without a write");
	a_irq_release_idle: assert property (idle_cnt >= 4'h2 |-> !$rose(irq_oe_n))
		else $error("interrupt released without host access");
	a_upper_table_cause: assert property (idle_cnt == 4'hf && $changed(o_pin[12]) |->
		$past(i_pin[10:8], 1) != $past(i_pin[10:8], 5))
		else $error("pin 12 moved without select change");
	a_lower_table_cause: assert property (idle_cnt == 4'hf && $changed(o_pin[4]) |->
		$past(i_pin[2:0], 1) != $past(i_pin[2:0], 5))
		else $error("pin 4 moved without select change");

	c_full_frame: cover property (stop_w && rises == 6'h1c);
	c_refused_frame: cover property (stop_w && rises == 6'h0a);
	c_irq_raised: cover property ($fell(irq_oe_n));
	c_boost_on: cover property ($rose(o_boost));
endmodule

// ==== tb/tb_gpio_expander_pld_and_irq_clear.sv ====
`timescale 1ns/1ps
`include "gx_map.svh"
// Drives the controller over Wishbone and the expander pins
module tb_gpio_expander_pld_and_irq_clear;
	typedef struct {logic [7:0] ra; logic [7:0] wd; logic bst;} gx_row_s;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_wd = 32'h0;
	logic [31:0] wb_rd;
	logic        wb_ack;
	logic        h_int;
	logic [15:0] pin = 16'hffff;
	logic [15:0] o_pin;
	logic [15:0] o_pin_oe_n;
	logic [15:0] o_pullup;
	logic        o_boost;
	logic [7:0]  rd;
	logic [31:0] w;
	int          fails = 0;
	int          check_count = 0;
	int          cycles = 0;
	gx_row_s     rows [6] = '{'{`GX_LUT_U, 8'ha5, 1'b0}, '{`GX_LUT_L, 8'h3d, 1'b0}, '{`GX_ADV, 8'h04, 1'b0},
		'{`GX_ADV, 8'h02, 1'b1}, '{`GX_DIR_A, 8'hff, 1'b1}, '{`GX_PUP_A, 8'hff, 1'b1}};

	gx_link_if lnk ();
	gx_host gx_host_inst (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_cyc), .i_wb_we(wb_we),
		.i_wb_adr(wb_adr), .i_wb_sel(4'hf), .i_wb_dat(wb_wd), .o_wb_dat(wb_rd), .o_wb_ack(wb_ack),
		.o_int(h_int), .lnk(lnk));
	gx_dev gx_dev_inst (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .i_pin(pin), .o_pin(o_pin),
		.o_pin_oe_n(o_pin_oe_n), .o_pullup(o_pullup), .o_boost(o_boost));
	gx_monitor gx_monitor_inst (.i_clk(i_clk), .i_rst(i_rst), .scl(lnk.scl), .sda(lnk.sda),
		.h_sda_oe_n(lnk.h_sda_oe_n), .d_sda_oe_n(lnk.d_sda_oe_n), .irq_oe_n(lnk.irq_oe_n), .i_pin(pin),
		.o_pin(o_pin), .o_boost(o_boost));

	// Clock
	always #25 i_clk = ~i_clk;

	// Verdict and end of run
	task automatic report_and_stop();
		if (fails == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Value comparison
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One classic Wishbone cycle, held until ack
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		wb_cyc <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wd <= d;
		do @(posedge i_clk); while (wb_ack !== 1'b1);
		q = wb_rd;
		wb_cyc <= 1'b0;
	endtask

	// One link transfer through the controller, polled until done
	task automatic xfer(input logic [6:0] da, input logic rw, input logic [7:0] ra, input logic [7:0] wd);
		logic [31:0] s;
		wb(1'b1, `GX_H_WDATA, {24'h0, wd}, s);
		wb(1'b1, `GX_H_CTRL, {9'h0, da, ra, 6'h0, rw, 1'b1}, s);
		do wb(1'b0, `GX_H_STATUS, 32'h0, s); while (s[0] !== 1'b0);
		wb(1'b0, `GX_H_RDATA, 32'h0, s);
		rd = s[7:0];
	endtask

	task automatic dw(input logic [7:0] ra, input logic [7:0] wd);
		xfer(`GX_DEV_ADDR, 1'b0, ra, wd);
	endtask

	task automatic dr(input logic [7:0] ra);
		xfer(`GX_DEV_ADDR, 1'b1, ra, 8'h00);
	endtask

	// Cuts a hang short
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			report_and_stop();
		end
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		chk("oe_n rst", 16'hffff, o_pin_oe_n);
		repeat (3) @(posedge i_clk);
		foreach (rows[i]) begin
			dw(rows[i].ra, rows[i].wd);
			dr(rows[i].ra);
			chk("readback", 16'(rows[i].wd), 16'(rd));
			chk("boost", 16'(rows[i].bst), 16'(o_boost));
		end
		dw(`GX_DIR_B, 8'hff);
		dw(`GX_PUP_B, 8'hff);
		chk("dir", 16'hffff, o_pin_oe_n);
		chk("pullup", 16'hffff, o_pullup);
		pin <= 16'hfff8;
		repeat (6) @(posedge i_clk);
		chk("tables off", 16'h0, 16'({o_pin[12], o_pin[4]}));
		dw(`GX_MODE, 8'h0a);
		for (int s = 0; s < 8; s++) begin
			pin[10:8] <= 3'(s);
			pin[2:0] <= 3'(s);
			repeat (6) @(posedge i_clk);
			chk("tables", 16'({rows[0].wd[s], rows[1].wd[s]}), 16'({o_pin[12], o_pin[4]}));
		end
		pin <= 16'hffff;
		dw(`GX_MASK_A, 8'h00);
		dw(`GX_SNSH_A, 8'haa);
		dw(`GX_SNSL_A, 8'haa);
		dw(`GX_PEND_A, 8'hff);
		chk("irq idle", 16'h1, 16'(lnk.irq_n));
		pin[5] <= 1'b0;
		repeat (8) @(posedge i_clk);
		chk("irq fall", 16'h0, 16'(lnk.irq_n));
		dr(`GX_PEND_A);
		chk("source", 16'h20, 16'(rd));
		dr(`GX_DATA_A);
		chk("data", 16'hdf, 16'(rd));
		chk("irq held", 16'h0, 16'(lnk.irq_n));
		dw(`GX_PEND_A, 8'h20);
		chk("irq clear", 16'h1, 16'(lnk.irq_n));
		pin[5] <= 1'b1;
		repeat (8) @(posedge i_clk);
		chk("no rise irq", 16'h1, 16'(lnk.irq_n));
		dw(`GX_ADV, 8'h04);
		pin[5] <= 1'b0;
		repeat (8) @(posedge i_clk);
		chk("irq fall 2", 16'h0, 16'(lnk.irq_n));
		dr(`GX_DATA_A);
		chk("autoclear", 16'h1, 16'(lnk.irq_n));
		dr(`GX_PEND_A);
		chk("source clr", 16'h0, 16'(rd));
		wb(1'b0, `GX_H_ISTAT, 32'h0, w);
		chk("istat", 16'h5, w[15:0]);
		wb(1'b1, `GX_H_ISTAT, 32'h7, w);
		wb(1'b1, `GX_H_IMASK, 32'h1, w);
		xfer(7'h21, 1'b0, `GX_ADV, 8'h00);
		wb(1'b0, `GX_H_STATUS, 32'h0, w);
		chk("nack", 16'h2, w[15:0]);
		chk("int", 16'h1, 16'(h_int));
		wb(1'b1, `GX_H_ISTAT, 32'h3, w);
		repeat (2) @(posedge i_clk);
		chk("int clr", 16'h0, 16'(h_int));
		wb(1'b0, 8'h40, 32'h0, w);
		chk("unmapped", 16'h0, w[15:0]);
		dw(`GX_ADV, 8'h02);
		chk("boost on", 16'h1, 16'(o_boost));
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk("boost rst", 16'h0, 16'(o_boost));
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clk);
		dr(`GX_ADV);
		chk("adv rst", 16'h0, 16'(rd));
		dr(`GX_LUT_U);
		chk("table rst", 16'h0, 16'(rd));
		dw(`GX_DATA_B, 8'h5a);
		chk("pin out", 16'h005a, 16'(o_pin[15:8]));
		report_and_stop();
	end
endmodule
